/* sstat_regs.svh */
`ifndef SSTAT_REGS_SVH
`define SSTAT_REGS_SVH

// ==========================================================================
// Register geometry
// ==========================================================================
`define SSTAT_REG_WIDTH 16
`define SSTAT_BYTE_WIDTH 8

// ==========================================================================
// Operation group bit positions
// ==========================================================================
`define SSTAT_OP_LIST_RUNNING 14
`define SSTAT_OP_LIST_DONE 12
`define SSTAT_OP_SAMPLE_DONE 11
`define SSTAT_OP_CONST_CURRENT 10
`define SSTAT_OP_TRANSIENT_DONE 9
`define SSTAT_OP_CONST_VOLTAGE 8
`define SSTAT_OP_TRANSIENT_PRIMED 6
`define SSTAT_OP_AWAIT_TRIGGER 5
`define SSTAT_OP_SETTLING 1
`define SSTAT_OP_USED_MASK 16'h5F62

// ==========================================================================
// Questionable group bit positions
// ==========================================================================
`define SSTAT_QS_ABSORBING 14
`define SSTAT_QS_CURRENT_ERR 13
`define SSTAT_QS_VOLTAGE_ERR 12
`define SSTAT_QS_SLAVE_ERR 6
`define SSTAT_QS_THERMAL_ERR 3
`define SSTAT_QS_CURRENT_MODE_ERR 1
`define SSTAT_QS_VOLTAGE_MODE_ERR 0
`define SSTAT_QS_USED_MASK 16'h704B
`define SSTAT_QS_LATCH_MASK 16'h3000

// ==========================================================================
// Status byte summary positions
// ==========================================================================
`define SSTAT_SB_OPER_SUMMARY 7
`define SSTAT_SB_QUES_SUMMARY 3

// ==========================================================================
// Reset and preset values
// ==========================================================================
`define SSTAT_OP_ENAB_RESET 16'h0000
`define SSTAT_QS_ENAB_RESET 16'h0000
`define SSTAT_OP_ENAB_PRESET 16'h2001
`define SSTAT_QS_ENAB_PRESET 16'h00FF

`endif

/* sstat_pkg.sv */
package sstat_pkg;

    // ======================================================================
    // Host command codes
    // ======================================================================
    typedef enum logic [3:0] {
        SSTAT_CMD_OP_COND_QRY = 4'h0,
        SSTAT_CMD_OP_ENAB_WR = 4'h1,
        SSTAT_CMD_OP_ENAB_QRY = 4'h2,
        SSTAT_CMD_OP_EVENT_QRY = 4'h3,
        SSTAT_CMD_PRESET = 4'h4,
        SSTAT_CMD_QS_EVENT_QRY = 4'h5,
        SSTAT_CMD_QS_COND_QRY = 4'h6,
        SSTAT_CMD_QS_ENAB_WR = 4'h7,
        SSTAT_CMD_QS_ENAB_QRY = 4'h8
    } sstat_cmd_t;

    typedef logic [15:0] sstat_word_t;

endpackage

/* sstat_grp_if.sv */
`timescale 1ns/10ps

interface sstat_grp_if #(parameter int W = 16);
    logic [W-1:0] cond;
    logic [W-1:0] latch_mask;
    logic [W-1:0] enable;
    logic read_clear;
    logic [W-1:0] event_bits;
    logic summary;

    modport owner (
        output cond,
        output latch_mask,
        output enable,
        output read_clear,
        input event_bits,
        input summary
    );

    modport unit (
        input cond,
        input latch_mask,
        input enable,
        input read_clear,
        output event_bits,
        output summary
    );
endinterface

/* sstat_event_group.sv */
`timescale 1ns/10ps

module sstat_event_group #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Group link
    sstat_grp_if.unit grp
);

    typedef struct packed {
        logic [W-1:0] event_latch;
        logic [W-1:0] prev_cond;
    } sstat_grp_state_t;

    sstat_grp_state_t state_reg;
    sstat_grp_state_t state_next;
    logic [W-1:0] rise;

    // ======================================================================
    // Event latching
    // ======================================================================
    always_comb
    begin
        state_next = state_reg;
        rise = grp.cond & ~state_reg.prev_cond & grp.latch_mask; // R17
        state_next.prev_cond = grp.cond;
        if (grp.read_clear)
        begin
            state_next.event_latch = '0; // R6 R10
        end
        state_next.event_latch = state_next.event_latch | rise; // R5 R17
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign grp.event_bits = state_reg.event_latch;
    assign grp.summary = |(state_reg.event_latch & grp.enable); // R3 R15

endmodule

/* sstat_status_regs.sv */
`timescale 1ns/10ps
`include "sstat_regs.svh"

// How it works
// R1: The operation condition register follows the present flags each cycle and is returned on query.
// R2: Operation flags sit at bits 14, 12, 11, 10, 9, 8, 6, 5 and 1, all others unused.
// R3: Status byte bit 7 is the OR of operation event bits enabled by the operation enable mask.
// R4: Writing an integer loads the operation enable mask and its query returns it with unused bits cleared.
// R5: The operation event register is read-only and latches every event until read.
// R6: Reading the operation event register returns its value and then clears it.
// R7: The preset command loads 8193 into the operation mask and 255 into the questionable mask.
// R8: Only questionable bits 13 and 12 are latched into the questionable event register.
// R9: Questionable condition bits 0 and 1 are never latched as events.
// R10: Reading the questionable event register returns its value and then clears it.
// R11: Questionable flags sit at bits 14, 13, 12, 6, 3, 1 and 0, all others unused.
// R12: The questionable condition register shows present conditions unlatched, set meaning active.
// R13: Questionable bits 1 and 0 are both set while the output settles.
// R14: A set bit in any status or mask register means active or enabled.
// R15: Status byte bit 3 is the OR of questionable event bits enabled by the questionable mask.
// R16: Unused bit positions read as zero and ignore written values, except unused enable mask bits loaded by the preset command.
// R17: An event bit sets when its condition rises and stays set until the event register is read.
module sstat_status_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Operation flags
    input wire logic list_running_flag,
    input wire logic list_done_flag,
    input wire logic sample_done_flag,
    input wire logic constant_current_flag,
    input wire logic transient_done_flag,
    input wire logic constant_voltage_flag,
    input wire logic transient_primed_flag,
    input wire logic awaiting_trigger_flag,
    input wire logic settling_flag,
    // Questionable flags
    input wire logic absorbing_energy_flag,
    input wire logic current_error_flag,
    input wire logic voltage_error_flag,
    input wire logic slave_error_flag,
    input wire logic thermal_error_flag,
    input wire logic current_mode_error_flag,
    input wire logic voltage_mode_error_flag,
    // Host command port
    input wire logic cmd_valid,
    input wire sstat_pkg::sstat_cmd_t cmd_code,
    input wire logic [15:0] cmd_value,
    // Host answer port
    output logic resp_valid,
    output logic [15:0] resp_value,
    output logic cmd_error,
    // Status byte
    output logic [7:0] status_byte
);

    typedef struct packed {
        logic [15:0] op_enab;
        logic [15:0] qs_enab;
        logic resp_valid;
        logic [15:0] resp_value;
        logic cmd_error;
        logic [7:0] status_byte;
    } sstat_main_state_t;

    sstat_main_state_t state_reg;
    sstat_main_state_t state_next;
    sstat_pkg::sstat_word_t op_cond;
    sstat_pkg::sstat_word_t qs_cond;
    logic op_read;
    logic qs_read;

    sstat_grp_if #(.W(`SSTAT_REG_WIDTH)) op_grp ();
    sstat_grp_if #(.W(`SSTAT_REG_WIDTH)) qs_grp ();

    // ======================================================================
    // Condition assembly
    // ======================================================================
    always_comb
    begin
        op_cond = '0;
        op_cond[`SSTAT_OP_LIST_RUNNING] = list_running_flag; // R2
        op_cond[`SSTAT_OP_LIST_DONE] = list_done_flag; // R2
        op_cond[`SSTAT_OP_SAMPLE_DONE] = sample_done_flag; // R2
        op_cond[`SSTAT_OP_CONST_CURRENT] = constant_current_flag; // R2
        op_cond[`SSTAT_OP_TRANSIENT_DONE] = transient_done_flag; // R2
        op_cond[`SSTAT_OP_CONST_VOLTAGE] = constant_voltage_flag; // R2
        op_cond[`SSTAT_OP_TRANSIENT_PRIMED] = transient_primed_flag; // R2
        op_cond[`SSTAT_OP_AWAIT_TRIGGER] = awaiting_trigger_flag; // R2
        op_cond[`SSTAT_OP_SETTLING] = settling_flag; // R2
        qs_cond = '0;
        qs_cond[`SSTAT_QS_ABSORBING] = absorbing_energy_flag; // R11
        qs_cond[`SSTAT_QS_CURRENT_ERR] = current_error_flag; // R11
        qs_cond[`SSTAT_QS_VOLTAGE_ERR] = voltage_error_flag; // R11
        qs_cond[`SSTAT_QS_SLAVE_ERR] = slave_error_flag; // R11
        qs_cond[`SSTAT_QS_THERMAL_ERR] = thermal_error_flag; // R11
        qs_cond[`SSTAT_QS_CURRENT_MODE_ERR] = current_mode_error_flag | settling_flag; // R13
        qs_cond[`SSTAT_QS_VOLTAGE_MODE_ERR] = voltage_mode_error_flag | settling_flag; // R13
    end

    // ======================================================================
    // Event groups
    // ======================================================================
    assign op_read = cmd_valid && (cmd_code == sstat_pkg::SSTAT_CMD_OP_EVENT_QRY);
    assign qs_read = cmd_valid && (cmd_code == sstat_pkg::SSTAT_CMD_QS_EVENT_QRY);

    assign op_grp.cond = op_cond;
    assign op_grp.latch_mask = `SSTAT_OP_USED_MASK; // R5
    assign op_grp.enable = state_reg.op_enab;
    assign op_grp.read_clear = op_read; // R6

    assign qs_grp.cond = qs_cond;
    assign qs_grp.latch_mask = `SSTAT_QS_LATCH_MASK; // R8 R9
    assign qs_grp.enable = state_reg.qs_enab;
    assign qs_grp.read_clear = qs_read; // R10

    sstat_event_group #(
        .W(`SSTAT_REG_WIDTH)
    ) u_op_group (
        .clock(clock),
        .rstn(rstn),
        .grp(op_grp.unit)
    );

    sstat_event_group #(
        .W(`SSTAT_REG_WIDTH)
    ) u_qs_group (
        .clock(clock),
        .rstn(rstn),
        .grp(qs_grp.unit)
    );

    // ======================================================================
    // Command decode and answers
    // ======================================================================
    always_comb
    begin
        state_next = state_reg;
        state_next.resp_valid = 1'b0;
        state_next.cmd_error = 1'b0;
        state_next.status_byte = '0;
        state_next.status_byte[`SSTAT_SB_OPER_SUMMARY] = op_grp.summary; // R3 R14
        state_next.status_byte[`SSTAT_SB_QUES_SUMMARY] = qs_grp.summary; // R15 R14
        if (cmd_valid)
        begin
            state_next.resp_valid = 1'b1;
            state_next.resp_value = '0;
            case (cmd_code)
                sstat_pkg::SSTAT_CMD_OP_COND_QRY:
                begin
                    state_next.resp_value = op_cond; // R1
                end
                sstat_pkg::SSTAT_CMD_OP_ENAB_WR:
                begin
                    state_next.op_enab = cmd_value & `SSTAT_OP_USED_MASK; // R4 R16
                end
                sstat_pkg::SSTAT_CMD_OP_ENAB_QRY:
                begin
                    state_next.resp_value = state_reg.op_enab; // R4
                end
                sstat_pkg::SSTAT_CMD_OP_EVENT_QRY:
                begin
                    state_next.resp_value = op_grp.event_bits; // R6
                end
                sstat_pkg::SSTAT_CMD_PRESET:
                begin
                    state_next.op_enab = `SSTAT_OP_ENAB_PRESET; // R7
                    state_next.qs_enab = `SSTAT_QS_ENAB_PRESET; // R7
                end
                sstat_pkg::SSTAT_CMD_QS_EVENT_QRY:
                begin
                    state_next.resp_value = qs_grp.event_bits; // R10
                end
                sstat_pkg::SSTAT_CMD_QS_COND_QRY:
                begin
                    state_next.resp_value = qs_cond; // R12
                end
                sstat_pkg::SSTAT_CMD_QS_ENAB_WR:
                begin
                    state_next.qs_enab = cmd_value & `SSTAT_QS_USED_MASK; // R16
                end
                sstat_pkg::SSTAT_CMD_QS_ENAB_QRY:
                begin
                    state_next.resp_value = state_reg.qs_enab;
                end
                default:
                begin
                    state_next.resp_valid = 1'b0;
                    state_next.cmd_error = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg.op_enab <= `SSTAT_OP_ENAB_RESET;
            state_reg.qs_enab <= `SSTAT_QS_ENAB_RESET;
            state_reg.resp_valid <= 1'b0;
            state_reg.resp_value <= '0;
            state_reg.cmd_error <= 1'b0;
            state_reg.status_byte <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign resp_valid = state_reg.resp_valid;
    assign resp_value = state_reg.resp_value;
    assign cmd_error = state_reg.cmd_error;
    assign status_byte = state_reg.status_byte;

endmodule

/* sstat_host_model.sv */
`timescale 1ns/10ps

module sstat_host_model (
    // Clock
    input wire logic clock,
    // Answer port
    input wire logic resp_valid,
    input wire logic [15:0] resp_value,
    input wire logic cmd_error,
    // Command port
    output logic cmd_valid,
    output sstat_pkg::sstat_cmd_t cmd_code,
    output logic [15:0] cmd_value
);
    initial
    begin
        cmd_valid = 1'h0;
        cmd_code = sstat_pkg::SSTAT_CMD_OP_COND_QRY;
        cmd_value = 16'h0000;
    end

    // ======================================================================
    // Command transfer
    // ======================================================================
    // One command per call; released data is inverted so stale values never match.
    task automatic send(input logic [3:0] c, input logic [15:0] v,
                        output logic [15:0] r, output logic [1:0] f);
        @(posedge clock);
        cmd_valid <= 1'h1;
        cmd_code <= sstat_pkg::sstat_cmd_t'(c);
        cmd_value <= v;
        @(posedge clock);
        cmd_valid <= 1'h0;
        cmd_value <= ~v;
        #1;
        r = resp_value;
        f = {resp_valid, cmd_error};
    endtask
endmodule

/* sstat_status_regs_props.sv */
`timescale 1ns/10ps

module sstat_status_regs_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Operation flags
    input wire logic list_running_flag,
    input wire logic list_done_flag,
    input wire logic sample_done_flag,
    input wire logic constant_current_flag,
    input wire logic transient_done_flag,
    input wire logic constant_voltage_flag,
    input wire logic transient_primed_flag,
    input wire logic awaiting_trigger_flag,
    input wire logic settling_flag,
    // Questionable flags
    input wire logic absorbing_energy_flag,
    input wire logic current_error_flag,
    input wire logic voltage_error_flag,
    input wire logic slave_error_flag,
    input wire logic thermal_error_flag,
    input wire logic current_mode_error_flag,
    input wire logic voltage_mode_error_flag,
    // Host port
    input wire logic cmd_valid,
    input wire sstat_pkg::sstat_cmd_t cmd_code,
    input wire logic [15:0] cmd_value,
    input wire logic resp_valid,
    input wire logic [15:0] resp_value,
    input wire logic cmd_error,
    input wire logic [7:0] status_byte
);
    wire logic [3:0] cc = cmd_code;
    wire logic [1:0] md = {2{settling_flag}} | {current_mode_error_flag, voltage_mode_error_flag};
    wire logic [15:0] op_c = {1'h0, list_running_flag, 1'h0, list_done_flag, sample_done_flag,
        constant_current_flag, transient_done_flag, constant_voltage_flag, 1'h0,
        transient_primed_flag, awaiting_trigger_flag, 3'h0, settling_flag, 1'h0};
    wire logic [15:0] qs_c = {1'h0, absorbing_energy_flag, current_error_flag,
        voltage_error_flag, 5'h00, slave_error_flag, 2'h0, thermal_error_flag, 1'h0, md};

    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // ======================================================================
    // Assertions and cover points
    // ======================================================================
    a_answer_next: assert property (cmd_valid && cc <= 4'h8
        |=> resp_valid && !cmd_error) else $error("missing answer");
    a_bad_code: assert property (cmd_valid && cc > 4'h8
        |=> cmd_error && !resp_valid) else $error("bad code not refused");
    a_op_cond_live: assert property (cmd_valid && cc == 4'h0
        |=> resp_value == $past(op_c)) else $error("operation condition wrong");
    a_qs_cond_live: assert property (cmd_valid && cc == 4'h6
        |=> resp_value == $past(qs_c)) else $error("questionable condition wrong");
    a_op_mask_wr: assert property (cmd_valid && cc == 4'h1 ##1 !cmd_valid
        ##1 cmd_valid && cc == 4'h2 |=> resp_value == ($past(cmd_value, 3) & 16'h5F62))
        else $error("operation mask readback wrong");
    a_preset_op: assert property (cmd_valid && cc == 4'h4 ##1 !cmd_valid
        ##1 cmd_valid && cc == 4'h2 |=> resp_value == 16'h2001) else $error("preset op mask");
    a_preset_qs: assert property (cmd_valid && cc == 4'h4 ##1 !cmd_valid
        ##1 cmd_valid && cc == 4'h8 |=> resp_value == 16'h00FF) else $error("preset qs mask");
    a_qs_latch_only: assert property (cmd_valid && cc == 4'h5
        |=> (resp_value & 16'hCFFF) == 16'h0000) else $error("unlatched bit in event");
    a_op_evt_used: assert property (cmd_valid && cc == 4'h3
        |=> (resp_value & 16'hA09D) == 16'h0000) else $error("unused event bit set");
    a_byte_unused: assert property ((status_byte & 8'h77) == 8'h00)
        else $error("unused status byte bit set");

    c_preset: cover property (cmd_valid && cc == 4'h4);
    c_op_summary: cover property (status_byte[7]);
    c_qs_summary: cover property (status_byte[3]);
    c_refused: cover property (cmd_error);
endmodule

bind sstat_status_regs sstat_status_regs_props u_props (.clock(clock), .rstn(rstn),
    .list_running_flag(list_running_flag), .list_done_flag(list_done_flag),
    .sample_done_flag(sample_done_flag), .constant_current_flag(constant_current_flag),
    .transient_done_flag(transient_done_flag), .constant_voltage_flag(constant_voltage_flag),
    .transient_primed_flag(transient_primed_flag), .awaiting_trigger_flag(awaiting_trigger_flag),
    .settling_flag(settling_flag), .absorbing_energy_flag(absorbing_energy_flag),
    .current_error_flag(current_error_flag), .voltage_error_flag(voltage_error_flag),
    .slave_error_flag(slave_error_flag), .thermal_error_flag(thermal_error_flag),
    .current_mode_error_flag(current_mode_error_flag),
    .voltage_mode_error_flag(voltage_mode_error_flag), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_value(cmd_value), .resp_valid(resp_valid),
    .resp_value(resp_value), .cmd_error(cmd_error), .status_byte(status_byte));

/* tb_status_reporting_registers.sv */
`timescale 1ns/10ps

module tb_status_reporting_registers;
    logic clock = 1'h0;
    logic rstn = 1'h0;
    logic [8:0] opf = 9'h000;
    logic [6:0] qsf = 7'h00;
    logic cmd_valid;
    sstat_pkg::sstat_cmd_t cmd_code;
    logic [15:0] cmd_value;
    logic resp_valid;
    logic [15:0] resp_value;
    logic cmd_error;
    logic [7:0] status_byte;
    logic [15:0] v;
    logic [15:0] p;
    logic [15:0] r;
    logic [1:0] f;
    logic [7:0] sb;
    int fail_count = 0;
    int total_checks = 0;

    always #10 clock = ~clock;

    sstat_status_regs dut (.clock(clock), .rstn(rstn),
        .list_running_flag(opf[8]), .list_done_flag(opf[7]), .sample_done_flag(opf[6]),
        .constant_current_flag(opf[5]), .transient_done_flag(opf[4]),
        .constant_voltage_flag(opf[3]), .transient_primed_flag(opf[2]),
        .awaiting_trigger_flag(opf[1]), .settling_flag(opf[0]),
        .absorbing_energy_flag(qsf[6]), .current_error_flag(qsf[5]),
        .voltage_error_flag(qsf[4]), .slave_error_flag(qsf[3]), .thermal_error_flag(qsf[2]),
        .current_mode_error_flag(qsf[1]), .voltage_mode_error_flag(qsf[0]),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_value(cmd_value),
        .resp_valid(resp_valid), .resp_value(resp_value), .cmd_error(cmd_error),
        .status_byte(status_byte));

    sstat_host_model u_host (.clock(clock), .resp_valid(resp_valid), .resp_value(resp_value),
        .cmd_error(cmd_error), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_value(cmd_value));

    // ======================================================================
    // Expectations and checks
    // ======================================================================
    function automatic logic [15:0] op_vec(input logic [8:0] o);
        return {1'h0, o[8], 1'h0, o[7:3], 1'h0, o[2:1], 3'h0, o[0], 1'h0};
    endfunction

    function automatic logic [15:0] qs_vec(input logic [6:0] q, input logic s);
        return {1'h0, q[6:4], 5'h00, q[3], 2'h0, q[2], 1'h0, q[1:0] | {2{s}}};
    endfunction

    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask

    task automatic q(input logic [3:0] c, input logic [15:0] d, input logic [15:0] e);
        logic [15:0] rr;
        logic [1:0] ff;
        u_host.send(c, d, rr, ff);
        check("answer flags", (c > 4'h8) ? 16'h0001 : 16'h0002, {14'h0, ff});
        if (c <= 4'h8)
            check("answer value", e, rr);
    endtask

    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        fail_count++;
        finish_test();
    end

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial
    begin
        void'($urandom(32'h145c85d7));
        repeat (6) @(posedge clock);
        rstn <= 1'h1;
        q(4'h2, 16'h0000, 16'h0000);
        q(4'h8, 16'h0000, 16'h0000);
        for (int i = 0; i < 24; i++)
        begin
            @(posedge clock);
            opf <= (i == 0) ? 9'h1FF : 9'($urandom);
            qsf <= (i == 0) ? 7'h7F : 7'($urandom);
            #1;
            q(4'h0, 16'h0000, op_vec(opf));
            q(4'h6, 16'h0000, qs_vec(qsf, opf[0]));
        end
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 16'hFFFF : 16'($urandom);
            q(4'h1, v, 16'h0000);
            q(4'h2, 16'h0000, v & 16'h5F62);
            q(4'h7, v, 16'h0000);
            q(4'h8, 16'h0000, v & 16'h704B);
        end
        q(4'h4, 16'h0000, 16'h0000);
        q(4'h2, 16'h0000, 16'h2001);
        q(4'h4, 16'h0000, 16'h0000);
        q(4'h8, 16'h0000, 16'h00FF);
        for (int i = 0; i < 10; i++)
        begin
            p = (i == 0) ? 16'hFFFF : 16'($urandom);
            v = (i < 2) ? 16'hFFFF : 16'($urandom);
            q(4'h1, v, 16'h0000);
            q(4'h7, v, 16'h0000);
            @(posedge clock);
            opf <= 9'h000;
            qsf <= 7'h00;
            u_host.send(4'h3, 16'h0000, r, f);
            u_host.send(4'h5, 16'h0000, r, f);
            @(posedge clock);
            opf <= p[8:0];
            qsf <= p[15:9];
            repeat (3) @(posedge clock);
            #1;
            sb = {|(op_vec(p[8:0]) & v & 16'h5F62), 3'h0,
                |(qs_vec(p[15:9], p[0]) & v & 16'h3000), 3'h0};
            check("status byte", {8'h00, sb}, {8'h00, status_byte});
            q(4'h3, 16'h0000, op_vec(p[8:0]));
            q(4'h5, 16'h0000, qs_vec(p[15:9], p[0]) & 16'h3000);
            q(4'h3, 16'h0000, 16'h0000);
            q(4'h5, 16'h0000, 16'h0000);
            repeat (2) @(posedge clock);
            #1;
            check("status byte clear", 16'h0000, {8'h00, status_byte});
        end
        for (int c = 9; c < 16; c++)
            q(4'(c), 16'hFFFF, 16'h0000);
        finish_test();
    end
endmodule
